// ===== include/epcb_pkg.sv
// Package with offsets, widths, reset values and bus state codes of the counter bank
package epcb_pkg;
  // ==========================================================
  // Register offsets on the five register-select lines
  localparam logic [4:0] EPCB_OFS_VECTOR = 5'h12;
  localparam logic [4:0] EPCB_OFS_TS_ERR = 5'h18;
  localparam logic [4:0] EPCB_OFS_ALARM_CRC = 5'h19;
  localparam logic [4:0] EPCB_OFS_BAD_ALIGN = 5'h1a;
  localparam logic [4:0] EPCB_OFS_VIOL_HI = 5'h1c;
  localparam logic [4:0] EPCB_OFS_VIOL_LO = 5'h1d;
  localparam logic [4:0] EPCB_OFS_FAR_BLOCK = 5'h1e;
  localparam logic [4:0] EPCB_OFS_CHECKSUM = 5'h1f;
  // ==========================================================
  // Widths and reset values
  localparam int EPCB_DATA_W = 8;
  localparam logic [7:0] EPCB_VECTOR_RESET = 8'h00;
  localparam logic [7:0] EPCB_READ_IDLE = 8'h00;
  // Strobe synchroniser depth
  localparam int EPCB_SYNC_STAGES = 3;
  // Bus access state machine
  typedef enum logic [1:0]
  {
    EPCB_IDLE = 2'b00,
    EPCB_ACTIVE = 2'b01,
    EPCB_DONE = 2'b11
  } epcb_bus_state_type;
endpackage

// ===== rtl/epcb_counter.sv
// Generic wrapping event counter with host preset
`timescale 1ns/1ps
module epcb_counter
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic event_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] load_value_in,
  output logic [WIDTH-1:0] count_out
);
  // ==========================================================
  // Count register
  // Reset deliberately absent: contents survive any reset
  logic [WIDTH-1:0] count_q;
  logic unused_rst;
  assign unused_rst = rst_n_in;

  // Host load wins over an increment; max wraps to zero
  always_ff @(posedge clk_in)
  begin
    if (load_in)
    begin
      count_q <= load_value_in;
    end
    else if (event_in)
    begin
      count_q <= count_q + WIDTH'(1);
    end
  end

  assign count_out = count_q;
endmodule

// ===== rtl/epcb_top.sv
// Performance counter bank and interrupt vector of an E1 framer status page
// Operation
// - Vector byte clears itself after host read
// - Resets never alter counter contents
// - Host write presets counter value
// - Vector byte at 0x12 shows last category
// - Count bit errors in selected timeslot
// - Count multiframes with alarm and E-bit zero
// - Count errored frame alignment signals
// - Sixteen-bit violation counter at 0x1c/0x1d
// - Far-end block error count low byte 0x1e
// - Checksum error count low byte 0x1f
`timescale 1ns/1ps
module epcb_top
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CS_N_IN,
  input wire logic DATA_STROBE_N_IN,
  input wire logic RD_WR_N_IN,
  input wire logic [4:0] ADDR_IN,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE_OUT,
  input wire logic PAGE_SELECT_IN,
  input wire logic TS_BIT_ERROR_IN,
  input wire logic ERROR_TIMESLOT_SELECT_BIT_IN,
  input wire logic MULTIFRAME_END_IN,
  input wire logic REMOTE_ALARM_IN,
  input wire logic EBIT_ZERO_IN,
  input wire logic BAD_ALIGNMENT_IN,
  input wire logic VIOLATION_IN,
  input wire logic FAR_BLOCK_ERROR_IN,
  input wire logic CHECKSUM_FAIL_IN,
  input wire logic VECTOR_LOAD_IN,
  input wire logic [7:0] VECTOR_VALUE_IN
);
  // ==========================================================
  // Host strobe synchronisers (three stages, edges from 2 and 3)
  logic [2:0] cs_sync_q;
  logic [2:0] ds_sync_q;
  logic access_level;
  logic access_start;
  logic access_end;
  logic access_idle; // Release seen: stages 2 and 3 both high
  epcb_pkg::epcb_bus_state_type state_q;
  epcb_pkg::epcb_bus_state_type state_d;

  // Shift the chip select and strobe through their stages
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      cs_sync_q <= 3'h7;
      ds_sync_q <= 3'h7;
    end
    else
    begin
      cs_sync_q <= {cs_sync_q[1:0], CS_N_IN};
      ds_sync_q <= {ds_sync_q[1:0], DATA_STROBE_N_IN};
    end
  end

  // Access is live when chip select and strobe are low in stages 2 and 3
  assign access_level = ~cs_sync_q[1] & ~cs_sync_q[2] &
                        ~ds_sync_q[1] & ~ds_sync_q[2];
  // Release counts only once stages 2 and 3 agree, so a half-moved
  // strobe can neither end an access nor start a new one
  assign access_idle = (cs_sync_q[1] & cs_sync_q[2])
                       | (ds_sync_q[1] & ds_sync_q[2]);
  assign access_start = (state_q == epcb_pkg::EPCB_IDLE) & access_level;
  assign access_end = (state_q == epcb_pkg::EPCB_ACTIVE) & access_idle;

  // ==========================================================
  // Access sequencer: one action per strobe
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      epcb_pkg::EPCB_IDLE:
      begin
        // Wait for chip select and strobe
        if (access_level)
        begin
          state_d = epcb_pkg::EPCB_ACTIVE;
        end
      end
      epcb_pkg::EPCB_ACTIVE:
      begin
        // Hold until the strobe is released
        if (access_idle)
        begin
          state_d = epcb_pkg::EPCB_DONE;
        end
      end
      epcb_pkg::EPCB_DONE:
      begin
        state_d = epcb_pkg::EPCB_IDLE;
      end
      default:
      begin
        state_d = epcb_pkg::EPCB_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_q <= epcb_pkg::EPCB_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Latched access attributes at strobe start
  logic [4:0] addr_q;
  logic write_q;
  logic [7:0] wdata_q;
  logic write_pulse;
  logic read_done;

  // Capture address, direction and data once per access
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      addr_q <= 5'h00;
      write_q <= 1'b0;
      wdata_q <= 8'h00;
    end
    else if (access_start)
    begin
      addr_q <= ADDR_IN;
      write_q <= ~RD_WR_N_IN & PAGE_SELECT_IN;
      wdata_q <= DATA_IN;
    end
  end

  // Write acts once, when the strobe release ends the access
  assign write_pulse = (state_q == epcb_pkg::EPCB_ACTIVE) & access_end
                       & write_q;
  assign read_done = access_end & ~write_q & PAGE_SELECT_IN;

  // Per-register load strobes
  function automatic logic hit(input logic [4:0] ofs);
    hit = write_pulse & (addr_q == ofs);
  endfunction

  // ==========================================================
  // Qualified event sources
  logic ts_event;
  logic alarm_event;
  logic viol_lo_wrap;
  logic viol_hi_event;
  logic [7:0] ts_count;
  logic [7:0] alarm_count;
  logic [7:0] align_count;
  logic [7:0] viol_hi_count;
  logic [7:0] viol_lo_count;
  logic [7:0] far_count;
  logic [7:0] crc_count;

  // Timeslot errors counted only when the selection bit picks them
  assign ts_event = TS_BIT_ERROR_IN & ERROR_TIMESLOT_SELECT_BIT_IN;
  // Once per multiframe with alarm set and an E-bit zero
  assign alarm_event = MULTIFRAME_END_IN & REMOTE_ALARM_IN
                       & EBIT_ZERO_IN;
  // Carry into upper byte when lower byte rolls over
  assign viol_lo_wrap = VIOLATION_IN & (viol_lo_count == 8'hff)
                        & ~hit(epcb_pkg::EPCB_OFS_VIOL_LO);
  assign viol_hi_event = viol_lo_wrap;

  // ==========================================================
  // Counter instances
  epcb_counter #(.WIDTH(epcb_pkg::EPCB_DATA_W)) u_ts
  (
    .clk_in(CLK_IN), .rst_n_in(RST_N_IN), .event_in(ts_event),
    .load_in(hit(epcb_pkg::EPCB_OFS_TS_ERR)), .load_value_in(wdata_q),
    .count_out(ts_count)
  );
  epcb_counter #(.WIDTH(epcb_pkg::EPCB_DATA_W)) u_alarm
  (
    .clk_in(CLK_IN), .rst_n_in(RST_N_IN), .event_in(alarm_event),
    .load_in(hit(epcb_pkg::EPCB_OFS_ALARM_CRC)), .load_value_in(wdata_q),
    .count_out(alarm_count)
  );
  epcb_counter #(.WIDTH(epcb_pkg::EPCB_DATA_W)) u_align
  (
    .clk_in(CLK_IN), .rst_n_in(RST_N_IN), .event_in(BAD_ALIGNMENT_IN),
    .load_in(hit(epcb_pkg::EPCB_OFS_BAD_ALIGN)), .load_value_in(wdata_q),
    .count_out(align_count)
  );
  epcb_counter #(.WIDTH(epcb_pkg::EPCB_DATA_W)) u_viol_lo
  (
    .clk_in(CLK_IN), .rst_n_in(RST_N_IN), .event_in(VIOLATION_IN),
    .load_in(hit(epcb_pkg::EPCB_OFS_VIOL_LO)), .load_value_in(wdata_q),
    .count_out(viol_lo_count)
  );
  epcb_counter #(.WIDTH(epcb_pkg::EPCB_DATA_W)) u_viol_hi
  (
    .clk_in(CLK_IN), .rst_n_in(RST_N_IN), .event_in(viol_hi_event),
    .load_in(hit(epcb_pkg::EPCB_OFS_VIOL_HI)), .load_value_in(wdata_q),
    .count_out(viol_hi_count)
  );
  epcb_counter #(.WIDTH(epcb_pkg::EPCB_DATA_W)) u_far
  (
    .clk_in(CLK_IN), .rst_n_in(RST_N_IN), .event_in(FAR_BLOCK_ERROR_IN),
    .load_in(hit(epcb_pkg::EPCB_OFS_FAR_BLOCK)), .load_value_in(wdata_q),
    .count_out(far_count)
  );
  epcb_counter #(.WIDTH(epcb_pkg::EPCB_DATA_W)) u_crc
  (
    .clk_in(CLK_IN), .rst_n_in(RST_N_IN), .event_in(CHECKSUM_FAIL_IN),
    .load_in(hit(epcb_pkg::EPCB_OFS_CHECKSUM)), .load_value_in(wdata_q),
    .count_out(crc_count)
  );

  // ==========================================================
  // Interrupt category vector
  logic [7:0] vector_q;
  logic vector_read;

  assign vector_read = read_done & (addr_q == epcb_pkg::EPCB_OFS_VECTOR);

  // New category beats the read-clear in the same cycle
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      vector_q <= epcb_pkg::EPCB_VECTOR_RESET;
    end
    else if (VECTOR_LOAD_IN)
    begin
      vector_q <= VECTOR_VALUE_IN;
    end
    else if (vector_read)
    begin
      vector_q <= epcb_pkg::EPCB_VECTOR_RESET;
    end
  end

  // ==========================================================
  // Read data mux, registered
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic oe_q;

  // Select register contents by latched address
  always_comb
  begin
    unique case (addr_q)
      epcb_pkg::EPCB_OFS_VECTOR: rdata_d = vector_q;
      epcb_pkg::EPCB_OFS_TS_ERR: rdata_d = ts_count;
      epcb_pkg::EPCB_OFS_ALARM_CRC: rdata_d = alarm_count;
      epcb_pkg::EPCB_OFS_BAD_ALIGN: rdata_d = align_count;
      epcb_pkg::EPCB_OFS_VIOL_HI: rdata_d = viol_hi_count;
      epcb_pkg::EPCB_OFS_VIOL_LO: rdata_d = viol_lo_count;
      epcb_pkg::EPCB_OFS_FAR_BLOCK: rdata_d = far_count;
      epcb_pkg::EPCB_OFS_CHECKSUM: rdata_d = crc_count;
      default: rdata_d = epcb_pkg::EPCB_READ_IDLE;
    endcase
  end

  // Drive the bus during a read access of this page
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      rdata_q <= epcb_pkg::EPCB_READ_IDLE;
      oe_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      oe_q <= (state_q == epcb_pkg::EPCB_ACTIVE) & ~access_idle
              & ~write_q & PAGE_SELECT_IN;
    end
  end

  assign DATA_OUT = rdata_q;
  assign DATA_OE_OUT = oe_q;
endmodule

// ===== tb/epcb_top_checker.sv
// Port assertions for the performance counter bank
`timescale 1ns/1ps
module epcb_top_checker
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CS_N_IN,
  input wire logic DATA_STROBE_N_IN,
  input wire logic RD_WR_N_IN,
  input wire logic [4:0] ADDR_IN,
  input wire logic PAGE_SELECT_IN,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE_OUT
);
  // ==========================================================
  // Bus drive relations
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_drive_after_strobe: assert property (
    $rose(DATA_OE_OUT) |-> !$past(CS_N_IN, 3) && !$past(DATA_STROBE_N_IN, 3))
    else $error("bus driven without an earlier strobe");
  a_drive_only_read: assert property (
    $rose(DATA_OE_OUT) |-> RD_WR_N_IN && PAGE_SELECT_IN && !CS_N_IN)
    else $error("bus driven outside a selected read");
  a_drive_ends: assert property (
    $rose(DATA_STROBE_N_IN) && DATA_OE_OUT |-> ##[1:6] !DATA_OE_OUT)
    else $error("bus still driven after strobe release");
  a_drive_stays: assert property (
    DATA_OE_OUT && !DATA_STROBE_N_IN |=> DATA_OE_OUT)
    else $error("bus drive dropped under strobe");
  a_idle_no_drive: assert property (
    CS_N_IN [*8] |-> !DATA_OE_OUT)
    else $error("bus driven while deselected");
  a_write_no_drive: assert property (
    !CS_N_IN && !RD_WR_N_IN |-> !DATA_OE_OUT)
    else $error("bus driven during a write");
  a_reset_quiet: assert property (
    $rose(RST_N_IN) |-> $past(DATA_OUT) == 8'h00 && !$past(DATA_OE_OUT))
    else $error("outputs not quiet in reset");
  a_unmapped_zero: assert property (
    DATA_OE_OUT && !(ADDR_IN inside {5'h12, 5'h18, 5'h19, 5'h1a, 5'h1c,
    5'h1d, 5'h1e, 5'h1f}) |-> DATA_OUT == 8'h00)
    else $error("unmapped place read non-zero");
endmodule
bind epcb_top epcb_top_checker u_chk (.CLK_IN, .RST_N_IN, .CS_N_IN,
  .DATA_STROBE_N_IN, .RD_WR_N_IN, .ADDR_IN, .PAGE_SELECT_IN, .DATA_OUT,
  .DATA_OE_OUT);

// ===== tb/epcb_host.sv
// Host processor model speaking the strobe register port
`timescale 1ns/1ps
module epcb_host
(
  input wire logic clk_in,
  input wire logic oe_in,
  input wire logic [7:0] rdata_in,
  output logic cs_n_out,
  output logic ds_n_out,
  output logic rw_out,
  output logic [4:0] addr_out,
  output logic [7:0] wdata_out
);
  // Idle bus: deselected, strobe high
  initial
  begin
    cs_n_out = 1'b1;
    ds_n_out = 1'b1;
    rw_out = 1'b1;
    addr_out = 5'h00;
    wdata_out = 8'h00;
  end
  // Write: held six cycles, then released with data scrambled
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    ds_n_out <= 1'b0;
    rw_out <= 1'b0;
    addr_out <= a;
    wdata_out <= d;
    repeat (6) @(posedge clk_in);
    cs_n_out <= 1'b1;
    ds_n_out <= 1'b1;
    wdata_out <= ~d;
    repeat (6) @(posedge clk_in);
  endtask
  // Read: held until drive is seen, data taken at that edge
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output bit ok);
    int n;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    ds_n_out <= 1'b0;
    rw_out <= 1'b1;
    addr_out <= a;
    for (n = 0; n < 20 && oe_in !== 1'b1; n++) @(posedge clk_in);
    d = rdata_in;
    ok = (oe_in === 1'b1);
    cs_n_out <= 1'b1;
    ds_n_out <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask
endmodule

// ===== tb/epcb_tb_top.sv
// Self-checking bench for the performance counter bank
`timescale 1ns/1ps
module epcb_tb_top;
  logic clk, rst_n, page, tsel, alarm, ebz, vload;
  logic cs_n, ds_n, rw, oe;
  logic [7:0] vval, rdata, wdata, dout;
  logic [4:0] addr;
  logic [5:0] ev;
  int err_count, compares;
  logic [4:0] ofs [7] = '{5'h18, 5'h19, 5'h1a, 5'h1d, 5'h1c, 5'h1e, 5'h1f};
  logic [7:0] pre [7] = '{8'h10, 8'h20, 8'h30, 8'hff, 8'h12, 8'hff, 8'h40};
  logic [7:0] post [7] = '{8'h13, 8'h21, 8'h34, 8'h00, 8'h13, 8'h00, 8'h42};
  epcb_top dut
  (
    .CLK_IN(clk),
    .RST_N_IN(rst_n),
    .CS_N_IN(cs_n),
    .DATA_STROBE_N_IN(ds_n),
    .RD_WR_N_IN(rw),
    .ADDR_IN(addr),
    .DATA_IN(wdata),
    .DATA_OUT(dout),
    .DATA_OE_OUT(oe),
    .PAGE_SELECT_IN(page),
    .TS_BIT_ERROR_IN(ev[0]),
    .ERROR_TIMESLOT_SELECT_BIT_IN(tsel),
    .MULTIFRAME_END_IN(ev[1]),
    .REMOTE_ALARM_IN(alarm),
    .EBIT_ZERO_IN(ebz),
    .BAD_ALIGNMENT_IN(ev[2]),
    .VIOLATION_IN(ev[3]),
    .FAR_BLOCK_ERROR_IN(ev[4]),
    .CHECKSUM_FAIL_IN(ev[5]),
    .VECTOR_LOAD_IN(vload),
    .VECTOR_VALUE_IN(vval)
  );
  epcb_host host
  (
    .clk_in(clk),
    .oe_in(oe),
    .rdata_in(dout),
    .cs_n_out(cs_n),
    .ds_n_out(ds_n),
    .rw_out(rw),
    .addr_out(addr),
    .wdata_out(wdata)
  );
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Read a register and compare; a missing drive counts as an error
  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    bit ok;
    host.rd(a, rdata, ok);
    if (!ok)
    begin
      err_count++;
      $display("mismatch t=%0t drive=%h exp=%h", $time, ok, 1'b1);
    end
    chk(rdata, exp);
  endtask
  // One-cycle event pulses, spaced by a quiet cycle
  task automatic burst(input int b, input int n);
    repeat (n)
    begin
      @(posedge clk);
      ev[b] <= 1'b1;
      @(posedge clk);
      ev[b] <= 1'b0;
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    page = 1'b1;
    {tsel, alarm, ebz, vload, ev, vval} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ofs[i]) host.wr(ofs[i], pre[i]);
    foreach (ofs[i]) rdchk(ofs[i], pre[i]);
    tsel <= 1'b1;
    burst(0, 3);
    tsel <= 1'b0;
    burst(0, 2);
    for (int k = 0; k < 4; k++)
    begin
      {alarm, ebz} <= 2'(k);
      burst(1, 1);
    end
    burst(2, 4);
    burst(3, 1);
    burst(4, 1);
    burst(5, 2);
    foreach (ofs[i]) rdchk(ofs[i], post[i]);
    // Events on every cycle of a write: load must win its cycle
    ev[2] <= 1'b1;
    host.wr(5'h1a, 8'h55);
    ev[2] <= 1'b0;
    rdchk(5'h1a, 8'h57);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(5'h18, 8'h13);
    vval <= 8'h5a;
    vload <= 1'b1;
    @(posedge clk);
    vload <= 1'b0;
    host.wr(5'h12, 8'ha5);
    rdchk(5'h12, 8'h5a);
    rdchk(5'h12, 8'h00);
    page <= 1'b0;
    host.wr(5'h18, 8'h77);
    page <= 1'b1;
    rdchk(5'h18, 8'h13);
    host.wr(5'h13, 8'h55);
    rdchk(5'h13, 8'h00);
    close_out();
  end
  // Watchdog against a hung access
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule
